// *** hdl/lmu_unit.sv ***
/*
  Load and move instruction unit: decodes halfword and word loads with their
  cached and I/O forms plus the register and immediate moves, forms the
  effective address, issues the memory request, extends returned data and
  writes the result to the register file.
  Assumes one outstanding load at a time and a memory side that answers with
  a one-cycle mem_rvalid pulse carrying the whole aligned 32-bit word.
*/
// Functional notes
// RQ1 - Address is base plus sign-extended offset
// RQ2 - Signed halfword load sign-extends to 32
// RQ3 - Unsigned halfword load zero-extends to 32
// RQ4 - Halfword address must be even
// RQ5 - Word load writes memory word unchanged
// RQ6 - Word address must be multiple of four
// RQ7 - Cached loads may be served by cache
// RQ8 - Signed halfword I/O load bypasses cache
// RQ9 - Unsigned halfword I/O load bypasses cache
// RQ10 - Without cache, I/O loads act cached
// RQ11 - Register move is add with zero
// RQ12 - High move sets upper half, clears lower
// RQ13 - High move is OR-high from zero register
// RQ14 - Software keeps high immediate unsigned 16-bit
// RQ15 - Signed immediate move sign-extends to 32
// RQ16 - Signed move is add-immediate from zero
// RQ17 - Software keeps signed immediate in range
// RQ18 - Six-bit opcodes select each load form
// RQ19 - Base, destination, immediate fields fixed positions
`timescale 1ns/1ps
module lmu_unit
  import lmu_pkg::*;
#(
  parameter bit HAS_DCACHE = 1'b1
)
(
  input  wire logic                  clk_sys,
  input  wire logic                  srst,
  input  wire logic                  instr_valid,
  input  wire logic [31:0]           instr,
  output logic                       instr_ready,
  output lmu_pkg::lmu_mem_req_t      mem_req,
  input  wire logic                  mem_ready,
  input  wire logic                  mem_rvalid,
  input  wire logic [LMU_XLEN-1:0]   mem_rdata,
  output lmu_pkg::lmu_wb_t           wb,
  output logic                       misaligned,
  input  wire logic [LMU_RIDX_W-1:0] dbg_idx,
  output logic      [LMU_XLEN-1:0]   dbg_data
);

  typedef enum logic [1:0] {
    LMU_S_IDLE,
    LMU_S_REQ,
    LMU_S_WAIT
  } lmu_state_e_t;

  typedef struct packed {
    lmu_state_e_t          fsm;
    lmu_kind_t             kind;
    logic [1:0]            addr_low;
    logic [LMU_RIDX_W-1:0] dst;
    lmu_mem_req_t          req;
    lmu_wb_t               wb;
    logic                  misaligned;
  } lmu_state_t;

  lmu_state_t state;
  lmu_state_t next_state;

  lmu_dec_t            dec;
  logic [LMU_XLEN-1:0] rs_a;
  logic [LMU_XLEN-1:0] rs_b;
  logic [LMU_XLEN-1:0] imm_sext;
  logic [LMU_XLEN-1:0] eff_addr;
  logic [15:0]         half_sel;
  logic                accept;

  function automatic logic [LMU_XLEN-1:0] sext16(input logic [15:0] v);
    sext16 = {{16{v[15]}}, v};
  endfunction

  function automatic logic [3:0] lane_mask(input lmu_kind_t k, input logic [1:0] a);
    if (k == LMU_K_LOAD_W) begin
      lane_mask = 4'hf;
    end else begin
      lane_mask = a[1] ? 4'hc : 4'h3;
    end
  endfunction

  lmu_decode u_decode (
    .instr_valid (instr_valid),
    .instr       (instr),
    .dec         (dec)
  );

  lmu_regfile u_regfile (
    .clk_sys   (clk_sys),
    .srst      (srst),
    .wb        (state.wb),
    .rd_a_idx  (dec.base_source_reg),
    .rd_b_idx  (dbg_idx),
    .rd_a_data (rs_a),
    .rd_b_data (rs_b)
  );

  assign imm_sext    = sext16(dec.sixteen_bit_offset_field);
  assign eff_addr    = rs_a + imm_sext;                                   // RQ1
  assign instr_ready = (state.fsm == LMU_S_IDLE);
  assign accept      = instr_ready && dec.valid;
  assign half_sel    = state.addr_low[1] ? mem_rdata[31:16] : mem_rdata[15:0];

  always_comb begin
    next_state            = state;
    next_state.wb.we      = 1'b0;
    next_state.misaligned = 1'b0;
    case (state.fsm)
      LMU_S_IDLE: begin
        if (accept) begin
          case (dec.kind)
            LMU_K_ADD: begin
              // Second operand is the zero register, so the sum is the source
              next_state.wb.we   = 1'b1;                                    // RQ11
              next_state.wb.idx  = dec.result_reg;
              next_state.wb.data = rs_a;
            end
            LMU_K_ADDI: begin
              next_state.wb.we   = 1'b1;                                    // RQ15
              next_state.wb.idx  = dec.second_operand_reg;
              next_state.wb.data = rs_a + imm_sext;                         // RQ16
            end
            LMU_K_ORHI: begin
              next_state.wb.we   = 1'b1;                                    // RQ12
              next_state.wb.idx  = dec.second_operand_reg;
              next_state.wb.data = rs_a | {dec.sixteen_bit_offset_field,
                                           LMU_HALF_ZERO};                  // RQ13
            end
            LMU_K_LOAD_HS, LMU_K_LOAD_HU, LMU_K_LOAD_W: begin
              next_state.fsm          = LMU_S_REQ;
              next_state.kind         = dec.kind;
              next_state.dst          = dec.second_operand_reg;
              next_state.addr_low     = eff_addr[1:0];
              next_state.req.req      = 1'b1;
              next_state.req.addr     = eff_addr;
              next_state.req.byte_en  = lane_mask(dec.kind, eff_addr[1:0]);
              // Only I/O forms are forced past the cache, and only if one exists
              next_state.req.bypass   = dec.io && HAS_DCACHE;           // RQ7 RQ8 RQ9 RQ10
              // Alignment is software's duty; flag it, result stays undefined
              next_state.misaligned   = (dec.kind == LMU_K_LOAD_W)
                                        ? (eff_addr[1:0] != 2'b00)        // RQ6
                                        : eff_addr[0];                    // RQ4
            end
            default: begin
              next_state.fsm = LMU_S_IDLE;
            end
          endcase
        end
      end
      LMU_S_REQ: begin
        if (mem_ready) begin
          next_state.req.req = 1'b0;
          next_state.fsm     = LMU_S_WAIT;
        end
      end
      LMU_S_WAIT: begin
        if (mem_rvalid) begin
          next_state.fsm     = LMU_S_IDLE;
          next_state.wb.we   = 1'b1;
          next_state.wb.idx  = state.dst;
          case (state.kind)
            LMU_K_LOAD_HS: next_state.wb.data = sext16(half_sel);          // RQ2
            LMU_K_LOAD_HU: next_state.wb.data = {LMU_HALF_ZERO, half_sel}; // RQ3
            default:       next_state.wb.data = mem_rdata;                 // RQ5
          endcase
        end
      end
      default: begin
        next_state.fsm = LMU_S_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state     <= '0;
      state.fsm <= LMU_S_IDLE;
    end else begin
      state <= next_state;
    end
  end

  assign mem_req    = state.req;
  assign wb         = state.wb;
  assign misaligned = state.misaligned;
  assign dbg_data   = rs_b;

endmodule

// *** hdl/lmu_pkg.sv ***
/*
  Package for the load and move instruction unit: opcodes, field positions,
  kind, decode and carrier types.
  Assumes a 32-bit instruction word with a 6-bit opcode in the low bits.
*/
package lmu_pkg;

  localparam int unsigned LMU_XLEN      = 32;
  localparam int unsigned LMU_RIDX_W    = 5;
  localparam int unsigned LMU_NREGS     = 32;

  // Field positions inside the instruction word
  localparam int unsigned LMU_OP_LSB    = 0;
  localparam int unsigned LMU_OP_MSB    = 5;
  localparam int unsigned LMU_IMM_LSB   = 6;
  localparam int unsigned LMU_IMM_MSB   = 21;
  localparam int unsigned LMU_DST_LSB   = 22;
  localparam int unsigned LMU_DST_MSB   = 26;
  localparam int unsigned LMU_BASE_LSB  = 27;
  localparam int unsigned LMU_BASE_MSB  = 31;
  localparam int unsigned LMU_OPX_LSB   = 11;
  localparam int unsigned LMU_OPX_MSB   = 16;
  localparam int unsigned LMU_RES_LSB   = 17;
  localparam int unsigned LMU_RES_MSB   = 21;

  // Primary opcodes, plus the extended opcode that selects add
  localparam logic [5:0] LMU_OP_LDH     = 6'h0f;
  localparam logic [5:0] LMU_OP_LDHIO   = 6'h2f;
  localparam logic [5:0] LMU_OP_LDHU    = 6'h0b;
  localparam logic [5:0] LMU_OP_LDHUIO  = 6'h2b;
  localparam logic [5:0] LMU_OP_LDW     = 6'h17;
  localparam logic [5:0] LMU_OP_LDWIO   = 6'h37;
  localparam logic [5:0] LMU_OP_ADDI    = 6'h04;
  localparam logic [5:0] LMU_OP_ORHI    = 6'h34;
  localparam logic [5:0] LMU_OP_RTYPE   = 6'h3a;
  localparam logic [5:0] LMU_OPX_ADD    = 6'h31;

  localparam logic [4:0]  LMU_ZERO_REG  = 5'h0;
  localparam logic [31:0] LMU_WORD_RST  = 32'h0000_0000;
  localparam logic [15:0] LMU_HALF_ZERO = 16'h0000;

  typedef enum logic [2:0] {
    LMU_K_NONE,
    LMU_K_LOAD_HS,
    LMU_K_LOAD_HU,
    LMU_K_LOAD_W,
    LMU_K_ADD,
    LMU_K_ADDI,
    LMU_K_ORHI
  } lmu_kind_t;

  typedef struct packed {
    logic                  valid;
    lmu_kind_t             kind;
    logic                  io;
    logic [LMU_RIDX_W-1:0] base_source_reg;
    logic [LMU_RIDX_W-1:0] second_operand_reg;
    logic [LMU_RIDX_W-1:0] result_reg;
    logic [15:0]           sixteen_bit_offset_field;
  } lmu_dec_t;

  typedef struct packed {
    logic                req;
    logic                bypass;
    logic [LMU_XLEN-1:0] addr;
    logic [3:0]          byte_en;
  } lmu_mem_req_t;

  typedef struct packed {
    logic                  we;
    logic [LMU_RIDX_W-1:0] idx;
    logic [LMU_XLEN-1:0]   data;
  } lmu_wb_t;

endpackage

// *** hdl/lmu_decode.sv ***
/*
  Combinational decoder for the load and move instruction group.
  Assumes the instruction word is stable while instr_valid is high.
*/
`timescale 1ns/1ps
module lmu_decode
  import lmu_pkg::*;
(
  input  wire logic           instr_valid,
  input  wire logic [31:0]    instr,
  output lmu_pkg::lmu_dec_t   dec
);

  always_comb begin
    dec                          = '0;
    dec.base_source_reg          = instr[LMU_BASE_MSB:LMU_BASE_LSB];       // RQ19
    dec.second_operand_reg       = instr[LMU_DST_MSB:LMU_DST_LSB];         // RQ19
    dec.sixteen_bit_offset_field = instr[LMU_IMM_MSB:LMU_IMM_LSB];         // RQ19
    dec.result_reg               = instr[LMU_DST_MSB:LMU_DST_LSB];
    dec.kind                     = LMU_K_NONE;
    case (instr[LMU_OP_MSB:LMU_OP_LSB])                                   // RQ18
      LMU_OP_LDH:    dec.kind = LMU_K_LOAD_HS;
      LMU_OP_LDHIO: begin
        dec.kind = LMU_K_LOAD_HS;
        dec.io   = 1'b1;
      end
      LMU_OP_LDHU:   dec.kind = LMU_K_LOAD_HU;
      LMU_OP_LDHUIO: begin
        dec.kind = LMU_K_LOAD_HU;
        dec.io   = 1'b1;
      end
      LMU_OP_LDW:    dec.kind = LMU_K_LOAD_W;
      LMU_OP_LDWIO: begin
        dec.kind = LMU_K_LOAD_W;
        dec.io   = 1'b1;
      end
      // Move pseudoinstructions arrive as their base forms; no own opcodes
      LMU_OP_ADDI:   dec.kind = LMU_K_ADDI;                              // RQ16
      LMU_OP_ORHI:   dec.kind = LMU_K_ORHI;                              // RQ13
      LMU_OP_RTYPE: begin
        if (instr[LMU_OPX_MSB:LMU_OPX_LSB] == LMU_OPX_ADD) begin          // RQ11
          dec.kind       = LMU_K_ADD;
          dec.result_reg = instr[LMU_RES_MSB:LMU_RES_LSB];
        end
      end
      default:       dec.kind = LMU_K_NONE;
    endcase
    dec.valid = instr_valid && (dec.kind != LMU_K_NONE);
  end

endmodule

// *** hdl/lmu_regfile.sv ***
/*
  Register file, 32 words in flip-flops, two read ports, one write port.
  Assumes index zero is the zero register and always reads as zero.
*/
`timescale 1ns/1ps
module lmu_regfile
  import lmu_pkg::*;
(
  input  wire logic                  clk_sys,
  input  wire logic                  srst,
  input  lmu_pkg::lmu_wb_t           wb,
  input  wire logic [LMU_RIDX_W-1:0] rd_a_idx,
  input  wire logic [LMU_RIDX_W-1:0] rd_b_idx,
  output logic      [LMU_XLEN-1:0]   rd_a_data,
  output logic      [LMU_XLEN-1:0]   rd_b_data
);

  typedef struct packed {
    logic [LMU_NREGS-1:0][LMU_XLEN-1:0] word;
  } lmu_rf_state_t;

  lmu_rf_state_t state;
  lmu_rf_state_t next_state;

  always_comb begin
    next_state = state;
    if (wb.we && wb.idx != LMU_ZERO_REG) begin
      next_state.word[wb.idx] = wb.data;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign rd_a_data = (rd_a_idx == LMU_ZERO_REG) ? LMU_WORD_RST : state.word[rd_a_idx];
  assign rd_b_data = (rd_b_idx == LMU_ZERO_REG) ? LMU_WORD_RST : state.word[rd_b_idx];

endmodule

// *** tb/lmu_unit_props.sv ***
/* Port checker for lmu_unit.
   Assumes one clock and the synchronous reset srst. */
`timescale 1ns/1ps
module lmu_unit_props
  import lmu_pkg::*;
#(
  parameter bit HAS_DCACHE = 1'b1
)
(
  input wire logic             clk_sys,
  input wire logic             srst,
  input wire logic             instr_valid,
  input wire logic [31:0]      instr,
  input wire logic             instr_ready,
  input lmu_pkg::lmu_mem_req_t mem_req,
  input wire logic             mem_ready,
  input wire logic             mem_rvalid,
  input lmu_pkg::lmu_wb_t      wb,
  input wire logic             misaligned
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  logic take;
  logic rise;
  // Moves are only checked from the zero register; other sources need the file
  assign take = instr_valid && instr_ready && instr[31:27] == LMU_ZERO_REG;
  assign rise = mem_req.req && !mem_ready;
  req_hold_a: assert property (rise |=> mem_req.req && $stable(mem_req.addr))
    else $error("load request changed before acceptance");
  load_busy_a: assert property (mem_req.req |-> !instr_ready)
    else $error("instruction taken during a load");
  io_bypass_a: assert property ($rose(mem_req.req) |->
    mem_req.bypass == (HAS_DCACHE && $past(instr[5]))) else $error("wrong cache bypass");
  lane_pick_a: assert property ($rose(mem_req.req) |-> mem_req.byte_en ==
    ($past(instr[4:0]) == 5'h17 ? 4'hf : mem_req.addr[1] ? 4'hc : 4'h3)) else $error("lanes");
  align_flag_a: assert property ($rose(mem_req.req) |-> misaligned ==
    (mem_req.byte_en == 4'hf ? |mem_req.addr[1:0] : mem_req.addr[0])) else $error("align");
  high_move_a: assert property (take && instr[5:0] == LMU_OP_ORHI |=> wb.we &&
    wb.data == {$past(instr[21:6]), 16'h0000}) else $error("high move result");
  imm_move_a: assert property (take && instr[5:0] == LMU_OP_ADDI |=> wb.we &&
    $signed(wb.data) == $signed($past(instr[21:6]))) else $error("signed move result");
  load_done_a: assert property (mem_rvalid && !instr_ready |=> wb.we)
    else $error("load data not written");
  cv_bypass: cover property ($rose(mem_req.req) && mem_req.bypass);
  cv_stall: cover property (rise);
  cv_done: cover property (mem_rvalid ##1 wb.we);
endmodule
bind lmu_unit lmu_unit_props #(.HAS_DCACHE(HAS_DCACHE)) u_lmu_unit_props (
  .clk_sys(clk_sys), .srst(srst), .instr_valid(instr_valid), .instr(instr),
  .instr_ready(instr_ready), .mem_req(mem_req), .mem_ready(mem_ready),
  .mem_rvalid(mem_rvalid), .wb(wb), .misaligned(misaligned));

// *** tb/lmu_mem_model.sv ***
/* Memory side model: accepts one load, returns its word after a lag.
   Assumes the unit holds its request until mem_ready. */
`timescale 1ns/1ps
module lmu_mem_model
  import lmu_pkg::*;
(
  input wire logic            clk_sys,
  input wire logic            srst,
  input lmu_pkg::lmu_mem_req_t mem_req,
  input wire logic [1:0]      lag,
  output logic                mem_ready,
  output logic                mem_rvalid,
  output logic [LMU_XLEN-1:0] mem_rdata
);
  logic [1:0]  cnt;
  logic        pend;
  logic [31:0] addr;
  always @(posedge clk_sys) begin
    mem_ready <= 1'b0;
    mem_rvalid <= 1'b0;
    // Data is only good with rvalid; toggling exposes a late sample
    mem_rdata <= ~mem_rdata;
    if (srst) begin
      pend <= 1'b0;
      mem_rdata <= 32'h0000_0000;
    end else if (pend) begin
      cnt <= cnt - 2'h1;
      if (cnt == 2'h0) begin
        pend <= 1'b0;
        mem_rvalid <= 1'b1;
        mem_rdata <= {addr[31:2], 2'b00} ^ 32'h9e37_79b9;
      end
    end else if (mem_req.req && !mem_ready) begin
      mem_ready <= 1'b1;
      addr <= mem_req.addr;
      cnt <= lag;
      pend <= 1'b1;
    end
  end
endmodule

// *** tb/tb_lmu_unit.sv ***
/* Bench for lmu_unit: random loads and moves against a register model.
   Assumes lmu_mem_model answers every load. */
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin bad_count++; \
  $display("unexpected at %0t: got %h want %h", $time, g, e); end end
module tb_lmu_unit;
  import lmu_pkg::*;
  localparam logic [5:0] OPS [10] = '{LMU_OP_LDH, LMU_OP_LDHIO, LMU_OP_LDHU,
    LMU_OP_LDHUIO, LMU_OP_LDW, LMU_OP_LDWIO, LMU_OP_ADDI, LMU_OP_ORHI, LMU_OP_ADDI, LMU_OP_RTYPE};
  logic         clk_sys = 1'b0;
  logic         srst = 1'b1;
  logic         instr_valid = 1'b0;
  logic [31:0]  instr = 32'h0000_0000;
  logic [4:0]   dbg_idx = 5'h00;
  logic [1:0]   lag = 2'h0;
  logic         mem_ready, mem_rvalid, misaligned, rdy, rdy2, mis2;
  logic [31:0]  mem_rdata, dbg_data, dbg2;
  lmu_mem_req_t mem_req, req2;
  lmu_wb_t      wb, wb2;
  logic [31:0]  rm [32];
  int           bad_count = 0;
  int           cmp_count = 0;
  int           seed = 32'haefb_60e5;
  always #5 clk_sys = ~clk_sys;
  lmu_unit #(.HAS_DCACHE(1'b1)) u_lmu_unit (.clk_sys(clk_sys), .srst(srst),
    .instr_valid(instr_valid), .instr(instr), .instr_ready(rdy), .mem_req(mem_req),
    .mem_ready(mem_ready), .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata), .wb(wb),
    .misaligned(misaligned), .dbg_idx(dbg_idx), .dbg_data(dbg_data));
  // Cacheless twin fed the same answers must write the same results
  lmu_unit #(.HAS_DCACHE(1'b0)) u_lmu_unit_nc (.clk_sys(clk_sys), .srst(srst),
    .instr_valid(instr_valid), .instr(instr), .instr_ready(rdy2), .mem_req(req2),
    .mem_ready(mem_ready), .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata), .wb(wb2),
    .misaligned(mis2), .dbg_idx(dbg_idx), .dbg_data(dbg2));
  lmu_mem_model u_lmu_mem_model (.clk_sys(clk_sys), .srst(srst), .mem_req(mem_req),
    .lag(lag), .mem_ready(mem_ready), .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata));
  task automatic print_verdict();
    $display("comparisons %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic run_one();
    logic [31:0] ea, wd, ex;
    logic [15:0] im, h;
    logic [4:0]  a, d;
    logic [3:0]  be;
    int          k, n;
    bit          seen;
    k = {$random(seed)} % 10;
    im = $random(seed);
    a = (k == 6 || k == 7) ? 5'h00 : 5'($random(seed));
    d = $random(seed);
    seen = 0;
    ea = rm[a] + {{16{im[15]}}, im};
    if (k < 6) begin
      im = im - 16'(ea & (k > 3 ? 3 : 1));
      ea = rm[a] + {{16{im[15]}}, im};
    end
    wd = {ea[31:2], 2'b00} ^ 32'h9e37_79b9;
    h = ea[1] ? wd[31:16] : wd[15:0];
    be = k > 3 ? 4'hf : ea[1] ? 4'hc : 4'h3;
    case (k)
      0, 1: ex = {{16{h[15]}}, h};
      2, 3: ex = {16'h0000, h};
      4, 5: ex = wd;
      7: ex = {im, 16'h0000};
      9: ex = rm[a];
      default: ex = ea;
    endcase
    @(posedge clk_sys);
    instr_valid <= 1'b1;
    instr <= k == 9 ? {a, 5'h00, d, LMU_OPX_ADD, 5'h00, LMU_OP_RTYPE} : {a, d, im, OPS[k]};
    dbg_idx <= d;
    lag <= 2'($random(seed));
    @(posedge clk_sys);
    instr_valid <= 1'b0;
    n = 0;
    do begin
      @(negedge clk_sys);
      n++;
      if (mem_req.req === 1'b1 && !seen) begin
        seen = 1;
        `CHK(mem_req.addr, ea)
        `CHK(mem_req.byte_en, be)
        `CHK(mem_req.bypass, 1'(k % 2 == 1))
        `CHK(req2.bypass, 1'b0)
        `CHK(misaligned, 1'b0)
        `CHK(rdy, 1'b0)
      end
    end while (wb.we !== 1'b1 && n < 40);
    if (wb.we !== 1'b1) begin
      bad_count++;
      $display("unexpected at %0t: no write back", $time);
      print_verdict();
    end else begin
      `CHK(wb.idx, d)
      `CHK(wb.data, ex)
      `CHK(wb2.we, 1'b1)
      `CHK(wb2.data, ex)
      if (d != 5'h00) rm[d] = ex;
      @(negedge clk_sys);
      `CHK(dbg_data, rm[d])
    end
  endtask
  initial begin
    foreach (rm[i]) rm[i] = 32'h0000_0000;
    repeat (4) @(posedge clk_sys);
    srst <= 1'b0;
    repeat (150) run_one();
    // Reset between instructions must leave the unit idle with a cleared file
    @(posedge clk_sys);
    srst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    `CHK(rdy, 1'b1)
    `CHK({mem_req, wb, misaligned}, 77'h0)
    @(posedge clk_sys);
    srst <= 1'b0;
    foreach (rm[i]) rm[i] = 32'h0000_0000;
    $display("mid-run reset done");
    repeat (150) run_one();
    $display("random load and move sequence done");
    print_verdict();
  end
endmodule
